// >>> apc_pkg.sv
`default_nettype none
package apc_pkg;
	// ----------------------------------------------------------------
	// Register port layout
	// ----------------------------------------------------------------
	localparam int          ADDR_W     = 3;
	localparam int          DATA_W     = 16;
	localparam logic [2:0]  A_DATA     = 3'h0;
	localparam logic [2:0]  A_SECCNT   = 3'h1;
	localparam logic [2:0]  A_CMD_STAT = 3'h2;
	localparam logic [2:0]  A_PWR      = 3'h3;
	localparam int          ST_BSY     = 7;
	localparam int          ST_RDY     = 6;
	localparam int          ST_DRQ     = 3;
	localparam logic [7:0]  SC_RST     = 8'h00;

	// ----------------------------------------------------------------
	// Command codes (each power command has two codes)
	// ----------------------------------------------------------------
	localparam logic [7:0] C_SIMM_A  = 8'hE0;
	localparam logic [7:0] C_SIMM_B  = 8'h94;
	localparam logic [7:0] C_IIMM_A  = 8'hE1;
	localparam logic [7:0] C_IIMM_B  = 8'h95;
	localparam logic [7:0] C_STBY_A  = 8'hE2;
	localparam logic [7:0] C_STBY_B  = 8'h96;
	localparam logic [7:0] C_IDLE_A  = 8'hE3;
	localparam logic [7:0] C_IDLE_B  = 8'h97;
	localparam logic [7:0] C_CHK_A   = 8'hE5;
	localparam logic [7:0] C_CHK_B   = 8'h98;
	localparam logic [7:0] C_SLEEP_A = 8'hE6;
	localparam logic [7:0] C_SLEEP_B = 8'h99;
	localparam logic [7:0] C_RDBUF   = 8'hE4;
	localparam logic [7:0] C_WRBUF   = 8'hE8;
	localparam logic [7:0] C_IDENT   = 8'hEC;

	// ----------------------------------------------------------------
	// Sector count values and standby timer encoding
	// ----------------------------------------------------------------
	localparam logic [7:0]  SC_PWR_STBY  = 8'h00;
	localparam logic [7:0]  SC_PWR_IDLE  = 8'hFF;
	localparam logic [7:0]  SC_DONE      = 8'h00;
	localparam logic [7:0]  SC_OFF       = 8'h00;
	localparam logic [7:0]  SC_SHORT_MAX = 8'hF0;
	localparam logic [7:0]  SC_HALF_MAX  = 8'hFB;
	localparam logic [7:0]  SC_21M       = 8'hFC;
	localparam logic [7:0]  SC_LONG      = 8'hFD;
	localparam logic [7:0]  SC_RSVD      = 8'hFE;
	localparam logic [15:0] T_STEP_S     = 16'h0005;
	localparam logic [15:0] T_HALFHR_S   = 16'h0708;
	localparam logic [15:0] T_21M_S      = 16'h04EC;
	localparam logic [15:0] T_21M15_S    = 16'h04FB;
	localparam logic [15:0] T_10H_S      = 16'h8CA0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned TICK_NS  = 1_000_000_000;
	localparam int unsigned CLK_NS   = 8;
	localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
	localparam int          TICK_W   = 27;

	// ----------------------------------------------------------------
	// Sector buffer and parameter words
	// ----------------------------------------------------------------
	localparam int          PTR_W     = 8;
	localparam int          BUF_WORDS = 256;
	localparam logic [7:0]  PTR_LAST  = 8'hFF;
	localparam logic [7:0]  ID_IX0    = 8'h00;
	localparam logic [7:0]  ID_IX49   = 8'h31;
	localparam logic [7:0]  ID_IX50   = 8'h32;
	localparam logic [15:0] ID_W0     = 16'h0040;
	localparam logic [15:0] ID_W49    = 16'h2F00;
	localparam logic [15:0] ID_W50    = 16'h4000;

	typedef enum logic [2:0] {
		PW_SPINUP, PW_IDLE, PW_SPINDN, PW_STBY, PW_SLEEP
	} apc_pw_t;
	typedef enum logic [2:0] {
		CS_IDLE, CS_SEQ, CS_FILL, CS_XFER, CS_PWAIT, CS_DISK
	} apc_cs_t;
endpackage
`default_nettype wire

// >>> apc_cmd_unit.sv
// The plain strobed port and the placing of the registers are this design's own decisions.
`default_nettype none
module apc_cmd_unit #(
	parameter int unsigned TICK_CYCLES = apc_pkg::TICK_CYC
) (
	input  wire logic                       mclk,
	input  wire logic                       rst_b,
	input  wire logic [apc_pkg::ADDR_W-1:0] addr,
	input  wire logic [apc_pkg::DATA_W-1:0] wdata,
	input  wire logic                       wr_stb,
	input  wire logic                       rd_stb,
	output logic      [apc_pkg::DATA_W-1:0] rdata,
	output logic                            intrq,
	output logic                            spindle_on,
	output logic                            disk_go,
	input  wire logic                       disk_done,
	input  wire logic                       spin_ready_pin,
	input  wire logic                       soft_rst_pin
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	apc_pkg::apc_pw_t                  pw_r;
	apc_pkg::apc_pw_t                  tgt_r;
	apc_pkg::apc_cs_t                  cs_r;
	logic                              to_sleep_r;
	logic [2:0]                        sync_r [2];
	logic [1:0]                        filt_r;
	logic                              srst_d_r;
	logic                              spin_rdy;
	logic                              srst_rise;
	logic [7:0]                        sc_r;
	logic [1:0]                        step_r;
	logic                              busy_r;
	logic                              drq_r;
	logic                              dir_wr_r;
	logic [apc_pkg::PTR_W-1:0]         ptr_r;
	logic [apc_pkg::DATA_W-1:0]        mem [apc_pkg::BUF_WORDS];
	logic                              tmr_en_r;
	logic                              tmr_run_r;
	logic [15:0]                       tmr_secs_r;
	logic [15:0]                       tmr_cnt_r;
	logic [apc_pkg::TICK_W-1:0]        tick_r;
	logic                              tick_last;
	logic                              tmr_exp;
	logic                              tmr_start;
	logic [7:0]                        code;
	logic                              cmd_wr;
	logic                              c_si, c_ii, c_stby, c_idle, c_chk;
	logic                              c_sleep, c_rb, c_wb, c_id, c_disk;
	logic                              go_dn;
	logic                              go_up;
	logic                              dat_rd;
	logic                              dat_wr;
	logic                              stat_rd;
	logic [apc_pkg::DATA_W-1:0]        status;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic is_code(input logic [7:0] c,
	                                 input logic [7:0] a,
	                                 input logic [7:0] b);
		return (c == a) || (c == b);
	endfunction

	// Timer length in seconds for a sector count value
	function automatic logic [15:0] secs_of(input logic [7:0] sc);
		logic [15:0] s;
		s = 16'h0000;
		if (sc <= apc_pkg::SC_SHORT_MAX)
			s = 16'(sc) * apc_pkg::T_STEP_S;
		else if (sc <= apc_pkg::SC_HALF_MAX)
			s = 16'(8'(sc - apc_pkg::SC_SHORT_MAX))
			    * apc_pkg::T_HALFHR_S;
		else if (sc == apc_pkg::SC_21M)
			s = apc_pkg::T_21M_S;
		else if (sc == apc_pkg::SC_LONG)
			s = apc_pkg::T_10H_S;
		else if (sc != apc_pkg::SC_RSVD)
			s = apc_pkg::T_21M15_S;
		return s;
	endfunction

	// Parameter words; unlisted words read as zero
	function automatic logic [15:0] id_word(input logic [7:0] ix);
		logic [15:0] w;
		w = 16'h0000;
		if (ix == apc_pkg::ID_IX0)
			w = apc_pkg::ID_W0;
		else if (ix == apc_pkg::ID_IX49)
			w = apc_pkg::ID_W49;
		else if (ix == apc_pkg::ID_IX50)
			w = apc_pkg::ID_W50;
		return w;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Three stages; a level counts once stages two and three agree
	for (genvar i = 0; i < 2; i++) begin : g_sync
		logic pin;
		assign pin = (i == 0) ? spin_ready_pin : soft_rst_pin;
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				sync_r[i] <= 3'h0;
				filt_r[i] <= 1'b0;
			end else begin
				sync_r[i] <= {sync_r[i][1:0], pin};
				if (sync_r[i][1] == sync_r[i][2])
					filt_r[i] <= sync_r[i][2];
			end
		end
	end
	assign spin_rdy = filt_r[0];

	// Soft reset acts on its rising edge only
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			srst_d_r <= 1'b0;
		else
			srst_d_r <= filt_r[1];
	end
	assign srst_rise = filt_r[1] && !srst_d_r;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	// Commands are refused in sleep and while busy
	assign code    = wdata[7:0];
	assign cmd_wr  = wr_stb && (addr == apc_pkg::A_CMD_STAT)
	                 && (pw_r != apc_pkg::PW_SLEEP)
	                 && ((cs_r == apc_pkg::CS_IDLE)
	                     || (cs_r == apc_pkg::CS_XFER));
	assign c_si    = is_code(code, apc_pkg::C_SIMM_A, apc_pkg::C_SIMM_B);
	assign c_ii    = is_code(code, apc_pkg::C_IIMM_A, apc_pkg::C_IIMM_B);
	assign c_stby  = is_code(code, apc_pkg::C_STBY_A, apc_pkg::C_STBY_B);
	assign c_idle  = is_code(code, apc_pkg::C_IDLE_A, apc_pkg::C_IDLE_B);
	assign c_chk   = is_code(code, apc_pkg::C_CHK_A, apc_pkg::C_CHK_B);
	assign c_sleep = is_code(code, apc_pkg::C_SLEEP_A, apc_pkg::C_SLEEP_B);
	assign c_rb    = (code == apc_pkg::C_RDBUF);
	assign c_wb    = (code == apc_pkg::C_WRBUF);
	assign c_id    = (code == apc_pkg::C_IDENT);
	// Anything else is a disk access handled by the media path
	assign c_disk  = !(c_si || c_ii || c_stby || c_idle || c_chk
	                   || c_sleep || c_rb || c_wb || c_id);
	assign go_dn   = cmd_wr && (c_si || c_stby || c_sleep);
	assign go_up   = cmd_wr && (c_ii || c_idle || c_disk);
	assign dat_rd  = rd_stb && (addr == apc_pkg::A_DATA)
	                 && (cs_r == apc_pkg::CS_XFER) && !dir_wr_r;
	assign dat_wr  = wr_stb && (addr == apc_pkg::A_DATA)
	                 && (cs_r == apc_pkg::CS_XFER) && dir_wr_r;
	assign stat_rd = rd_stb && (addr == apc_pkg::A_CMD_STAT);

	// ----------------------------------------------------------------
	// Power state
	// ----------------------------------------------------------------
	// Spindle settle is judged by the synchronised ready pin
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pw_r       <= apc_pkg::PW_SPINUP;
			to_sleep_r <= 1'b0;
		end else if (srst_rise) begin
			if (pw_r == apc_pkg::PW_SLEEP)
				pw_r <= apc_pkg::PW_STBY;
		end else begin
			unique case (pw_r)
				apc_pkg::PW_SPINUP: begin
					if (go_dn) begin
						pw_r       <= apc_pkg::PW_SPINDN;
						to_sleep_r <= c_sleep;
					end else if (spin_rdy)
						pw_r <= apc_pkg::PW_IDLE;
				end
				apc_pkg::PW_IDLE: begin
					if (go_dn || tmr_exp) begin
						pw_r       <= apc_pkg::PW_SPINDN;
						to_sleep_r <= go_dn && c_sleep;
					end
				end
				apc_pkg::PW_SPINDN: begin
					if (go_up)
						pw_r <= apc_pkg::PW_SPINUP;
					else begin
						if (go_dn && c_sleep)
							to_sleep_r <= 1'b1;
						if (!spin_rdy)
							pw_r <= (to_sleep_r || (go_dn && c_sleep))
							        ? apc_pkg::PW_SLEEP
							        : apc_pkg::PW_STBY;
					end
				end
				apc_pkg::PW_STBY: begin
					// Standby-type commands are no-ops here
					if (go_dn && c_sleep)
						pw_r <= apc_pkg::PW_SLEEP;
					else if (go_up)
						pw_r <= apc_pkg::PW_SPINUP;
				end
				apc_pkg::PW_SLEEP: ;
			endcase
		end
	end

	// Spindle runs while spinning up or idle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			spindle_on <= 1'b0;
		else
			spindle_on <= (pw_r == apc_pkg::PW_SPINUP)
			              || (pw_r == apc_pkg::PW_IDLE);
	end

	// ----------------------------------------------------------------
	// Standby timer
	// ----------------------------------------------------------------
	// Counts only in idle, so standby and sleep leave it frozen
	assign tick_last = (tick_r == apc_pkg::TICK_W'(TICK_CYCLES - 1));
	assign tmr_exp   = tmr_run_r && tmr_en_r
	                   && (pw_r == apc_pkg::PW_IDLE)
	                   && tick_last && (tmr_cnt_r == 16'h0001);
	assign tmr_start = (cmd_wr && (c_ii || c_idle))
	                   || ((cs_r == apc_pkg::CS_DISK)
	                       && (step_r == 2'h1) && disk_done);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tmr_en_r   <= 1'b0;
			tmr_run_r  <= 1'b0;
			tmr_secs_r <= 16'h0000;
			tmr_cnt_r  <= 16'h0000;
			tick_r     <= '0;
		end else begin
			if (cmd_wr && (c_stby || c_idle)) begin
				// Zero and the reserved code disable the timer
				tmr_en_r   <= (code != apc_pkg::SC_OFF)
				              && (sc_r != apc_pkg::SC_OFF)
				              && (sc_r != apc_pkg::SC_RSVD);
				tmr_secs_r <= secs_of(sc_r);
			end
			if (tmr_start) begin
				tmr_run_r <= 1'b1;
				tmr_cnt_r <= (cmd_wr && c_idle) ? secs_of(sc_r)
				             : tmr_secs_r;
				tick_r    <= '0;
			end else if (go_dn || tmr_exp) begin
				tmr_run_r <= 1'b0;
			end else if (tmr_run_r && tmr_en_r
			             && (pw_r == apc_pkg::PW_IDLE)) begin
				tick_r <= tick_last ? '0 : tick_r + 1'b1;
				if (tick_last)
					tmr_cnt_r <= tmr_cnt_r - 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sector count register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			sc_r <= apc_pkg::SC_RST;
		else if (cmd_wr && c_chk)
			sc_r <= (pw_r == apc_pkg::PW_IDLE) ? apc_pkg::SC_PWR_IDLE
			        : apc_pkg::SC_PWR_STBY;
		else if (cmd_wr && (c_rb || c_wb || c_id))
			sc_r <= apc_pkg::SC_DONE;
		else if (wr_stb && (addr == apc_pkg::A_SECCNT))
			sc_r <= wdata[7:0];
	end

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------
	// A new command aborts an open buffer transfer
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cs_r     <= apc_pkg::CS_IDLE;
			tgt_r    <= apc_pkg::PW_IDLE;
			step_r   <= 2'h0;
			busy_r   <= 1'b0;
			drq_r    <= 1'b0;
			dir_wr_r <= 1'b0;
			ptr_r    <= '0;
			intrq    <= 1'b0;
			disk_go  <= 1'b0;
		end else begin
			disk_go <= 1'b0;
			// Status read clears the interrupt; a set below wins
			if (stat_rd)
				intrq <= 1'b0;
			if (srst_rise) begin
				cs_r   <= apc_pkg::CS_IDLE;
				busy_r <= 1'b0;
				drq_r  <= 1'b0;
			end else if (cmd_wr) begin
				drq_r <= 1'b0;
				if (c_rb) begin
					busy_r   <= 1'b1;
					step_r   <= 2'h0;
					dir_wr_r <= 1'b0;
					cs_r     <= apc_pkg::CS_SEQ;
				end else if (c_wb) begin
					ptr_r    <= '0;
					drq_r    <= 1'b1;
					dir_wr_r <= 1'b1;
					cs_r     <= apc_pkg::CS_XFER;
				end else if (c_id) begin
					busy_r   <= 1'b1;
					ptr_r    <= '0;
					dir_wr_r <= 1'b0;
					cs_r     <= apc_pkg::CS_FILL;
				end else if (c_si || c_stby || c_chk) begin
					intrq <= 1'b1;
					cs_r  <= apc_pkg::CS_IDLE;
				end else if (c_ii || c_idle || c_sleep) begin
					busy_r <= 1'b1;
					tgt_r  <= c_sleep ? apc_pkg::PW_SLEEP
					          : apc_pkg::PW_IDLE;
					cs_r   <= apc_pkg::CS_PWAIT;
				end else begin
					busy_r <= 1'b1;
					step_r <= 2'h0;
					cs_r   <= apc_pkg::CS_DISK;
				end
			end else begin
				unique case (cs_r)
					apc_pkg::CS_IDLE: ;
					apc_pkg::CS_SEQ: begin
						step_r <= step_r + 2'h1;
						if (step_r == 2'h0)
							ptr_r <= '0;
						else if (step_r == 2'h1)
							drq_r <= 1'b1;
						else if (step_r == 2'h2)
							busy_r <= 1'b0;
						else begin
							intrq <= 1'b1;
							cs_r  <= apc_pkg::CS_XFER;
						end
					end
					apc_pkg::CS_FILL: begin
						ptr_r <= ptr_r + 1'b1;
						if (ptr_r == apc_pkg::PTR_LAST) begin
							step_r <= 2'h1;
							cs_r   <= apc_pkg::CS_SEQ;
						end
					end
					apc_pkg::CS_XFER: begin
						// One sector window, 256 words
						if (dat_rd || dat_wr) begin
							ptr_r <= ptr_r + 1'b1;
							if (ptr_r == apc_pkg::PTR_LAST) begin
								drq_r <= 1'b0;
								cs_r  <= apc_pkg::CS_IDLE;
								if (dir_wr_r)
									intrq <= 1'b1;
							end
						end
					end
					apc_pkg::CS_PWAIT: begin
						if (pw_r == tgt_r) begin
							busy_r <= 1'b0;
							intrq  <= 1'b1;
							cs_r   <= apc_pkg::CS_IDLE;
						end
					end
					apc_pkg::CS_DISK: begin
						if (step_r == 2'h0) begin
							if (pw_r == apc_pkg::PW_IDLE) begin
								disk_go <= 1'b1;
								step_r  <= 2'h1;
							end
						end else if (disk_done) begin
							busy_r <= 1'b0;
							intrq  <= 1'b1;
							cs_r   <= apc_pkg::CS_IDLE;
						end
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Sector buffer and read port
	// ----------------------------------------------------------------
	// No reset on the array: contents are undefined until filled
	always_ff @(posedge mclk) begin
		if (cs_r == apc_pkg::CS_FILL)
			mem[ptr_r] <= id_word(ptr_r);
		else if (dat_wr)
			mem[ptr_r] <= wdata;
	end

	assign status = {8'h00, busy_r,
	                 (pw_r == apc_pkg::PW_IDLE)
	                 || (pw_r == apc_pkg::PW_STBY),
	                 2'h0, drq_r, 3'h0};

	// Read data stand for one cycle only
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			rdata <= '0;
		else if (!rd_stb)
			rdata <= '0;
		else if (addr == apc_pkg::A_DATA)
			rdata <= dat_rd ? mem[ptr_r] : '0;
		else if (addr == apc_pkg::A_SECCNT)
			rdata <= {8'h00, sc_r};
		else if (addr == apc_pkg::A_CMD_STAT)
			rdata <= status;
		else if (addr == apc_pkg::A_PWR)
			rdata <= {13'h0000, pw_r};
		else
			rdata <= '0;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	stby_imm_dn_a: assert property (cmd_wr && c_si && pw_r == apc_pkg::PW_IDLE
		|=> pw_r == apc_pkg::PW_SPINDN) else $error("no spin down");
	stby_noop_a: assert property (cmd_wr && c_si && pw_r == apc_pkg::PW_STBY
		|=> pw_r == apc_pkg::PW_STBY && !tmr_run_r)
		else $error("standby no-op broken");
	early_irq_a: assert property (cmd_wr && c_si && pw_r == apc_pkg::PW_IDLE
		|=> intrq && pw_r != apc_pkg::PW_STBY)
		else $error("late standby irq");
	pw_irq_a: assert property ($rose(intrq) && $past(cs_r) == apc_pkg::CS_PWAIT
		|-> pw_r == tgt_r) else $error("irq before power state");
	tmr_exp_a: assert property (tmr_exp |=> pw_r == apc_pkg::PW_SPINDN)
		else $error("expiry ignored");
	chk_pwr_a: assert property (cmd_wr && c_chk && pw_r != apc_pkg::PW_IDLE
		|=> sc_r == apc_pkg::SC_PWR_STBY) else $error("bad power code");
	sleep_hold_a: assert property (pw_r == apc_pkg::PW_SLEEP && !srst_rise
		|=> pw_r == apc_pkg::PW_SLEEP) else $error("sleep left");
	rdbuf_seq_a: assert property (cmd_wr && c_rb |=> busy_r ##2
		(drq_r && busy_r) ##1 (drq_r && !busy_r) ##1 intrq)
		else $error("read buffer order");
	rdy_bit_a: assert property (stat_rd && pw_r == apc_pkg::PW_STBY
		|=> rdata[apc_pkg::ST_RDY]) else $error("ready missing");

	rdbuf_c: cover property (cmd_wr && c_rb ##[1:8] cs_r == apc_pkg::CS_XFER);
	ident_c: cover property (cs_r == apc_pkg::CS_FILL
		&& ptr_r == apc_pkg::PTR_LAST);
	expire_c: cover property (tmr_exp);
	sleep_c: cover property (pw_r == apc_pkg::PW_SLEEP ##1 srst_rise);
endmodule // apc_cmd_unit
`default_nettype wire

// >>> apc_media_model.sv
`default_nettype none
// ----------------------------------------------------------------
// Spindle and media path stand-in
// ----------------------------------------------------------------
module apc_media_model (
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic spindle_on,
	input  wire logic disk_go,
	output logic      spin_ready_pin,
	output logic      disk_done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] spin_cnt_r;
	logic [2:0] acc_cnt_r;

	// Motor takes eleven cycles to follow the request either way
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			spin_cnt_r     <= 4'h0;
			spin_ready_pin <= 1'b0;
		end else if (spindle_on == spin_ready_pin) begin
			spin_cnt_r <= 4'h0;
		end else if (spin_cnt_r == 4'hA) begin
			spin_ready_pin <= spindle_on;
		end else begin
			spin_cnt_r <= spin_cnt_r + 4'h1;
		end
	end

	// Access ends five cycles after the go pulse, one pulse only
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			acc_cnt_r <= 3'h0;
		end else if (disk_go) begin
			acc_cnt_r <= 3'h1;
		end else if (acc_cnt_r != 3'h0) begin
			acc_cnt_r <= acc_cnt_r + 3'h1;
		end
	end
	assign disk_done = (acc_cnt_r == 3'h5);
endmodule // apc_media_model
`default_nettype wire

// >>> ata_power_buffer_cmd_unit_tb_top.sv
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
$display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module ata_power_buffer_cmd_unit_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk, rst_b, wr_stb, rd_stb, soft_rst_pin;
	logic spindle_on, disk_go, disk_done, spin_ready_pin, intrq;
	logic [2:0]  addr;
	logic [15:0] wdata, rdata, d;
	int n_errors = 0;
	int samples_checked = 0;

	apc_cmd_unit #(.TICK_CYCLES(4)) apc_cmd_unit_inst (.mclk(mclk),
		.rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .intrq(intrq),
		.spindle_on(spindle_on), .disk_go(disk_go), .disk_done(disk_done),
		.spin_ready_pin(spin_ready_pin), .soft_rst_pin(soft_rst_pin));
	apc_media_model apc_media_model_inst (.mclk(mclk), .rst_b(rst_b),
		.spindle_on(spindle_on), .disk_go(disk_go),
		.spin_ready_pin(spin_ready_pin), .disk_done(disk_done));

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [2:0] a, input logic [15:0] v);
		@(posedge mclk); addr <= a; wdata <= v; wr_stb <= 1'b1;
		@(posedge mclk); wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] v);
		@(posedge mclk); addr <= a; rd_stb <= 1'b1;
		@(posedge mclk); rd_stb <= 1'b0;
		#1 v = rdata;
	endtask
	// Count must be in place before the command is written
	task automatic cmd(input logic [7:0] sc, input logic [7:0] c);
		wr(apc_pkg::A_SECCNT, {8'h00, sc});
		wr(apc_pkg::A_CMD_STAT, {8'h00, c});
	endtask
	// Poll power state, bounded
	task automatic wp(input apc_pkg::apc_pw_t s);
		for (int i = 0; i < 300; i++) begin
			rd(apc_pkg::A_PWR, d);
			if (d[2:0] === s) break;
		end
		`CHK(d[2:0], s)
	endtask
	// Wait for interrupt, then read status to clear it
	task automatic wi(output logic [15:0] st);
		// Look just after the edge so the flop has settled
		for (int i = 0; i < 600 && intrq !== 1'b1; i++) @(posedge mclk) #1;
		`CHK(intrq, 1'b1)
		rd(apc_pkg::A_CMD_STAT, st);
	endtask
	// One sector of 256 words each way; identify words or a pattern
	task automatic xfer(input bit wdir, input bit idf);
		logic [15:0] e;
		for (int i = 0; i < 256; i++) begin
			e = {i[7:0], ~i[7:0]};
			if (idf) e = (i == 0) ? apc_pkg::ID_W0 : (i == 49) ?
				apc_pkg::ID_W49 : (i == 50) ? apc_pkg::ID_W50 : 16'h0000;
			if (wdir) wr(apc_pkg::A_DATA, e);
			else begin rd(apc_pkg::A_DATA, d); `CHK(d, e) end
		end
	endtask
	task automatic summarize;
		$display("checked %0d, errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// Free-running clock, 8 ns
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Hang guard, well beyond the expected run
	initial begin
		#400000;
		n_errors++;
		summarize();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_b, wr_stb, rd_stb, soft_rst_pin, addr, wdata} = '0;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		wp(apc_pkg::PW_IDLE);
		rd(apc_pkg::A_CMD_STAT, d); `CHK(d[apc_pkg::ST_RDY], 1'b1)
		cmd(8'h00, apc_pkg::C_CHK_A); wi(d);
		rd(apc_pkg::A_SECCNT, d); `CHK(d[7:0], apc_pkg::SC_PWR_IDLE)
		$display("test power up done");
		cmd(8'h00, apc_pkg::C_SIMM_A); @(posedge mclk); #1;
		`CHK(intrq, 1'b1)
		rd(apc_pkg::A_PWR, d); `CHK(d[2:0], apc_pkg::PW_SPINDN)
		wi(d); wp(apc_pkg::PW_STBY);
		cmd(8'h00, apc_pkg::C_CHK_B); wi(d);
		rd(apc_pkg::A_SECCNT, d); `CHK(d[7:0], apc_pkg::SC_PWR_STBY)
		cmd(8'h00, apc_pkg::C_SIMM_B); wi(d);
		rd(apc_pkg::A_PWR, d); `CHK(d[2:0], apc_pkg::PW_STBY)
		`CHK(spindle_on, 1'b0)
		cmd(8'h00, apc_pkg::C_IIMM_B); wi(d);
		rd(apc_pkg::A_PWR, d); `CHK(d[2:0], apc_pkg::PW_IDLE)
		$display("test immediate done");
		cmd(8'h01, apc_pkg::C_IDLE_A); wi(d); repeat (10) @(posedge mclk);
		rd(apc_pkg::A_PWR, d); `CHK(d[2:0], apc_pkg::PW_IDLE)
		wp(apc_pkg::PW_STBY);
		cmd(8'hFE, apc_pkg::C_IDLE_B); wi(d); repeat (60) @(posedge mclk);
		rd(apc_pkg::A_PWR, d); `CHK(d[2:0], apc_pkg::PW_IDLE)
		cmd(8'h00, apc_pkg::C_STBY_A); wi(d); wp(apc_pkg::PW_STBY);
		cmd(8'h00, apc_pkg::C_IIMM_A); wi(d); repeat (60) @(posedge mclk);
		rd(apc_pkg::A_PWR, d); `CHK(d[2:0], apc_pkg::PW_IDLE)
		cmd(8'h02, apc_pkg::C_STBY_B); wi(d); wp(apc_pkg::PW_STBY);
		cmd(8'h00, 8'h20); wi(d);
		rd(apc_pkg::A_PWR, d); `CHK(d[2:0], apc_pkg::PW_IDLE)
		wp(apc_pkg::PW_STBY);
		$display("test timer done");
		cmd(8'h00, apc_pkg::C_WRBUF); repeat (2) @(posedge mclk);
		xfer(1'b1, 1'b0); wi(d); `CHK(d[apc_pkg::ST_DRQ], 1'b0)
		cmd(8'h00, apc_pkg::C_RDBUF); wi(d);
		`CHK(d[apc_pkg::ST_DRQ], 1'b1)
		`CHK(d[apc_pkg::ST_BSY], 1'b0)
		xfer(1'b0, 1'b0);
		rd(apc_pkg::A_CMD_STAT, d); `CHK(d[apc_pkg::ST_DRQ], 1'b0)
		cmd(8'h00, apc_pkg::C_IDENT); wi(d);
		`CHK(d[apc_pkg::ST_DRQ], 1'b1)
		xfer(1'b0, 1'b1);
		$display("test buffer done");
		cmd(8'h00, apc_pkg::C_SLEEP_A); wi(d);
		rd(apc_pkg::A_PWR, d); `CHK(d[2:0], apc_pkg::PW_SLEEP)
		cmd(8'h00, apc_pkg::C_IIMM_A); repeat (40) @(posedge mclk);
		rd(apc_pkg::A_PWR, d); `CHK(d[2:0], apc_pkg::PW_SLEEP)
		@(posedge mclk); soft_rst_pin <= 1'b1;
		repeat (8) @(posedge mclk); soft_rst_pin <= 1'b0;
		wp(apc_pkg::PW_STBY);
		$display("test sleep done");
		summarize();
	end
endmodule // ata_power_buffer_cmd_unit_tb_top
`default_nettype wire
